/* spisp_chk.sv */
// Purpose: port checker for the serial status and protection front end
// Assumes: pin edges reach the logic two to three clocks late
// Notes:   windows of six clocks cover the synchroniser delay
module spisp_chk #(
   parameter WRITE_CYCLES = 400000
) (
   input wire       CLK_SYS_I,
   input wire       RST_N_I,
   input wire       SEL_N_I,
   input wire       SCLK_I,
   input wire       SDI_I,
   input wire       GUARD_N_I,
   input wire       PAUSE_N_I,
   input wire       SDO_O,
   input wire       SDO_OE_O,
   input wire [1:0] PROTECT_LEVEL_O,
   input wire       BUSY_O
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RST_N_I);
   reg [31:0] bcnt_r;
   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I)
         bcnt_r <= 32'h0000_0000;
      else
         bcnt_r <= BUSY_O ? bcnt_r + 32'h0000_0001 : 32'h0000_0000;
   end
   sequence s_desel;
      SEL_N_I [*6];
   endsequence
   sequence s_busy8;
      BUSY_O [*8];
   endsequence
   property p_oe_off; s_desel |-> !SDO_OE_O; endproperty
   property p_pause_off; !PAUSE_N_I [*6] |-> !SDO_OE_O; endproperty
   // Clock high phase is only four samples at the bench rate
   property p_sdo_fall; SCLK_I [*4] |-> $stable(SDO_O); endproperty
   property p_busy_start; $rose(BUSY_O) |-> SEL_N_I; endproperty
   property p_busy_hold; $rose(BUSY_O) |-> s_busy8; endproperty
   property p_busy_len; $fell(BUSY_O) |-> bcnt_r + 2 >= WRITE_CYCLES && bcnt_r <= WRITE_CYCLES + 2; endproperty
   property p_lvl_sel; $changed(PROTECT_LEVEL_O) |-> SEL_N_I; endproperty
   property p_lvl_busy; BUSY_O && $past(BUSY_O) |-> $stable(PROTECT_LEVEL_O); endproperty
   a_oe_off: assert property (p_oe_off) else $error("output on while idle");
   a_pause_off: assert property (p_pause_off) else $error("output on while paused");
   a_sdo_fall: assert property (p_sdo_fall) else $error("data moved off clock fall");
   a_busy_start: assert property (p_busy_start) else $error("write began while selected");
   a_busy_hold: assert property (p_busy_hold) else $error("write cycle too short");
   a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
   a_lvl_sel: assert property (p_lvl_sel) else $error("level moved mid frame");
   a_lvl_busy: assert property (p_lvl_busy) else $error("level moved while busy");
endmodule // spisp_chk

bind spisp_top spisp_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.CLK_SYS_I, .RST_N_I, .SEL_N_I, .SCLK_I,
   .SDI_I, .GUARD_N_I, .PAUSE_N_I, .SDO_O, .SDO_OE_O, .PROTECT_LEVEL_O, .BUSY_O);

/* spisp_defs.vh */
// Purpose: constants for the serial EEPROM status and protection front end
// Assumes: 100 MHz system clock
// Notes:   opcodes compare bits 7:4 and 2:0, bit 3 is ignored
`ifndef SPISP_DEFS_VH
`define SPISP_DEFS_VH
`define SPISP_OP_SET_WEL    8'h06
`define SPISP_OP_CLR_WEL    8'h04
`define SPISP_OP_RD_STAT    8'h05
`define SPISP_OP_WR_STAT    8'h01
`define SPISP_OP_WR_ARRAY   8'h02
`define SPISP_OP_MASK       8'hF7
`define SPISP_BIT_READY     0
`define SPISP_BIT_WEL       1
`define SPISP_BIT_PL_LO     2
`define SPISP_BIT_PL_HI     3
`define SPISP_BIT_ARM       7
`define SPISP_BP_RESET      2'b00
`define SPISP_WRITE_TIME_US 4000
`define SPISP_CLK_MHZ       100
`define SPISP_WRITE_CYCLES  (`SPISP_WRITE_TIME_US * `SPISP_CLK_MHZ)
`endif

/* spisp_master.sv */
// Purpose: serial master model driving select, clock, data and pause
// Assumes: 80 ns serial period, mode 0 or 3
// Notes:   data line flips between frames so stale bits never look valid
module spisp_master (
   output logic sel_n_o,
   output logic sclk_o,
   output logic sdi_o,
   output logic pause_n_o,
   input  wire  sdo_i,
   input  wire  sdo_oe_i
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sel_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
      pause_n_o = 1'b1;
   end
   task automatic frame(input logic [15:0] d, input int n, input bit m3, input int pz, output logic [7:0] rx);
      sclk_o = m3;
      #40 sel_n_o = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--) begin
         sclk_o = 1'b0;
         if (i == pz) begin
            // Pause only moves with the clock low
            #40 pause_n_o = 1'b0;
            #400 pause_n_o = 1'b1;
         end
         sdi_o = d[i];
         #40 sclk_o = 1'b1;
         #20 rx = {rx[6:0], sdo_oe_i ? sdo_i : 1'bx};
         #20;
      end
      sclk_o = m3;
      #40 sel_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #200;
   endtask
endmodule // spisp_master

/* spisp_nvbits.v */
// Purpose: nonvolatile store for the two block protect bits and the arm bit
// Assumes: contents survive system reset; only changed by a write
// Notes:   read data come from a register
module spisp_nvbits #(
   parameter WIDTH = 3
) (
   input  wire             clk_i,
   input  wire             wr_i,
   input  wire [WIDTH-1:0] wdata_i,
   output reg  [WIDTH-1:0] rdata_o
);
   // Factory state is all zero; no reset, so power loss keeps the value
   initial rdata_o = {WIDTH{1'b0}};
   always @(posedge clk_i) begin
      if (wr_i) begin
         rdata_o <= wdata_i;
      end
   end
endmodule // spisp_nvbits

/* spisp_sync.v */
// Purpose: two flip-flop synchroniser for a group of pins
// Assumes: inputs are asynchronous to clk_i
// Notes:   first stage feeds only the second stage
module spisp_sync #(
   parameter       WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire [WIDTH-1:0] d_i,
   output reg  [WIDTH-1:0] q_o
);
   reg [WIDTH-1:0] meta_r;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= INIT;
         q_o    <= INIT;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule // spisp_sync

/* spisp_top.v */
// Purpose: serial slave front end, status register, write latch and protection
// Assumes: master uses clock mode 0 or 3, all pins asynchronous to CLK_SYS_I
// Notes:   array commands only clear the latch and start a write cycle
// How it works
// - Falling select starts a new instruction
// - Rising select ends operation, launches write
// - Standby after select high, after write
// - Output tristated while in standby
// - Modes 0 and 3, sample on rise
// - Output changes on serial clock fall
// - Guard active: pin low and arm set
// - Pause suspends clock, input and output
// - Pause pin high disables pausing
// - Status writable only unguarded with latch set
// - Bit0 busy; only status read while busy
// - Latch bit1, gates all writes, set command
// - Latch cleared at power up
// - Level bits pick protected array blocks
// - Level bits nonvolatile, factory zero
// - Bits 4 to 6 read zero when not writing
// - Guard protects only status register
// - Arm cannot drop while pin low
// - Status reads all ones while writing
// - Everything shifts most significant bit first
// - Set latch opcode 0000 X110
// - Clear latch after clear, status, array write
`include "spisp_defs.vh"
module spisp_top #(
   parameter WRITE_CYCLES = `SPISP_WRITE_CYCLES
) (
   input  wire       CLK_SYS_I,
   input  wire       RST_N_I,
   input  wire       SEL_N_I,
   input  wire       SCLK_I,
   input  wire       SDI_I,
   input  wire       GUARD_N_I,
   input  wire       PAUSE_N_I,
   output reg        SDO_O,
   output wire       SDO_OE_O,
   output wire [1:0] PROTECT_LEVEL_O,
   output wire       BUSY_O
);
   reg        rst_m_r;
   reg        rst_s_r;
   wire       rst_n;
   wire [4:0] pins_s;
   wire       sel_n_s;
   wire       sclk_s;
   wire       sdi_s;
   wire       guard_n_s;
   wire       pause_n_s;
   reg        sel_n_d_r;
   reg        sclk_d_r;
   reg        paused_r;
   reg        paused_nxt;
   reg        active_r;
   reg  [2:0] bit_cnt_r;
   reg  [7:0] shift_r;
   reg  [7:0] opcode_r;
   reg        have_op_r;
   reg  [7:0] out_r;
   reg        out_en_r;
   reg        got_data_r;
   reg  [7:0] wdata_r;
   reg        wel_r;
   reg        busy_r;
   reg [31:0] wcnt_r;
   reg        nv_wr;
   reg  [2:0] nv_wdata;
   wire [2:0] nv_bits;
   wire       guard_on;
   wire       sel_fall;
   wire       sel_rise;
   wire       sclk_rise;
   wire       sclk_fall;
   wire [7:0] status_val;
   wire [7:0] next_shift;
   wire       op_is_rd;
   wire       op_is_wr;
   wire       op_is_set;
   wire       op_is_clr;
   wire       op_is_arr;

   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_m_r <= 1'b0;
         rst_s_r <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_s_r <= rst_m_r;
      end
   end
   assign rst_n = rst_s_r;

   spisp_sync #(
      .WIDTH (5),
      .INIT  (5'b10011)
   ) u_sync (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_n),
      .d_i     ({SEL_N_I, SCLK_I, SDI_I, GUARD_N_I, PAUSE_N_I}),
      .q_o     (pins_s)
   );
   assign sel_n_s   = pins_s[4];
   assign sclk_s    = pins_s[3];
   assign sdi_s     = pins_s[2];
   assign guard_n_s = pins_s[1];
   assign pause_n_s = pins_s[0];

   spisp_nvbits #(
      .WIDTH (3)
   ) u_nv (
      .clk_i   (CLK_SYS_I),
      .wr_i    (nv_wr),
      .wdata_i (nv_wdata),
      .rdata_o (nv_bits)
   );

   assign guard_on  = ~guard_n_s & nv_bits[2];
   assign sel_fall  = sel_n_d_r & ~sel_n_s;
   assign sel_rise  = ~sel_n_d_r & sel_n_s;
   // Pause freezes edge detection; the master keeps the clock low around it
   assign sclk_rise = active_r & ~paused_nxt & ~sclk_d_r & sclk_s;
   assign sclk_fall = active_r & ~paused_nxt & sclk_d_r & ~sclk_s;
   assign next_shift = {shift_r[6:0], sdi_s};

   // Bits 4 to 6 are never stored; all ones while writing
   assign status_val = busy_r ? 8'hFF :
                       {nv_bits[2], 3'b000, nv_bits[1:0], wel_r, 1'b0};
   assign op_is_rd  = (opcode_r & `SPISP_OP_MASK) == `SPISP_OP_RD_STAT;
   assign op_is_wr  = (opcode_r & `SPISP_OP_MASK) == `SPISP_OP_WR_STAT;
   assign op_is_set = (opcode_r & `SPISP_OP_MASK) == `SPISP_OP_SET_WEL;
   assign op_is_clr = (opcode_r & `SPISP_OP_MASK) == `SPISP_OP_CLR_WEL;
   assign op_is_arr = (opcode_r & `SPISP_OP_MASK) == `SPISP_OP_WR_ARRAY;

   // Pause only takes effect with the clock low; high pin means never paused
   always @* begin
      paused_nxt = paused_r;
      if (!active_r || pause_n_s) begin
         paused_nxt = 1'b0;
      end else if (!sclk_s) begin
         paused_nxt = 1'b1;
      end
   end

   assign SDO_OE_O        = out_en_r & active_r & ~paused_r;
   assign PROTECT_LEVEL_O = nv_bits[1:0];
   assign BUSY_O          = busy_r;

   always @* begin
      nv_wr    = 1'b0;
      nv_wdata = nv_bits;
      // Arm is taken from the old value if it would drop with the pin low
      if (sel_rise && active_r && have_op_r && !busy_r && op_is_wr && got_data_r
          && wel_r && !guard_on) begin
         nv_wr       = 1'b1;
         nv_wdata[1] = wdata_r[`SPISP_BIT_PL_HI];
         nv_wdata[0] = wdata_r[`SPISP_BIT_PL_LO];
         nv_wdata[2] = (!guard_n_s && nv_bits[2]) ? 1'b1 : wdata_r[`SPISP_BIT_ARM];
      end
   end

   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         sel_n_d_r  <= 1'b1;
         sclk_d_r   <= 1'b0;
         paused_r   <= 1'b0;
         active_r   <= 1'b0;
         bit_cnt_r  <= 3'd0;
         shift_r    <= 8'h00;
         opcode_r   <= 8'h00;
         have_op_r  <= 1'b0;
         out_r      <= 8'h00;
         out_en_r   <= 1'b0;
         got_data_r <= 1'b0;
         wdata_r    <= 8'h00;
         wel_r      <= 1'b0;
         busy_r     <= 1'b0;
         wcnt_r     <= 32'd0;
         SDO_O      <= 1'b0;
      end else begin
         sel_n_d_r <= sel_n_s;
         paused_r  <= paused_nxt;
         if (!paused_nxt) begin
            sclk_d_r <= sclk_s;
         end
         if (busy_r) begin
            if (wcnt_r == WRITE_CYCLES - 1) begin
               busy_r <= 1'b0;
               wcnt_r <= 32'd0;
            end else begin
               wcnt_r <= wcnt_r + 32'd1;
            end
         end
         if (sel_fall) begin
            active_r   <= 1'b1;
            bit_cnt_r  <= 3'd0;
            have_op_r  <= 1'b0;
            got_data_r <= 1'b0;
            out_en_r   <= 1'b0;
            sclk_d_r   <= sclk_s;
         end else if (sel_rise) begin
            active_r <= 1'b0;
            out_en_r <= 1'b0;
            if (active_r && have_op_r && !busy_r) begin
               if (op_is_set) begin
                  wel_r <= 1'b1;
               end else if (op_is_clr) begin
                  wel_r <= 1'b0;
               end else if (op_is_wr && got_data_r) begin
                  wel_r <= 1'b0;
                  if (wel_r && !guard_on) begin
                     busy_r <= 1'b1;
                     wcnt_r <= 32'd0;
                  end
               end else if (op_is_arr && got_data_r) begin
                  wel_r <= 1'b0;
                  // Neither block level nor the guard is checked; only the latch gates it
                  if (wel_r) begin
                     busy_r <= 1'b1;
                     wcnt_r <= 32'd0;
                  end
               end
            end
         end else if (sclk_rise) begin
            shift_r   <= next_shift;
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7) begin
               if (!have_op_r) begin
                  opcode_r  <= next_shift;
                  have_op_r <= 1'b1;
                  if ((next_shift & `SPISP_OP_MASK) == `SPISP_OP_RD_STAT) begin
                     out_r <= status_val;
                  end
               end else if (!got_data_r) begin
                  wdata_r    <= next_shift;
                  got_data_r <= 1'b1;
               end else if (op_is_rd) begin
                  out_r <= status_val;
               end
            end
         end else if (sclk_fall && have_op_r && op_is_rd) begin
            SDO_O    <= out_r[7];
            out_r    <= {out_r[6:0], 1'b0};
            out_en_r <= 1'b1;
         end
      end
   end
endmodule // spisp_top

/* spisp_top_tb.sv */
// Purpose: self-checking bench for the status and protection front end
// Assumes: write cycle shortened to 400 clocks
// Notes:   every frame starts one ns after a system clock edge
module spisp_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk, rst_n, guard_n;
   logic [7:0] rx;
   wire        sel_n, sclk, sdi, pause_n, sdo, sdo_oe, busy;
   wire  [1:0] lvl;
   int         n_fail = 0;
   int         cmp_count = 0;
   spisp_top #(.WRITE_CYCLES(400)) uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .SEL_N_I(sel_n), .SCLK_I(sclk),
      .SDI_I(sdi), .GUARD_N_I(guard_n), .PAUSE_N_I(pause_n), .SDO_O(sdo), .SDO_OE_O(sdo_oe),
      .PROTECT_LEVEL_O(lvl), .BUSY_O(busy));
   spisp_master m (.sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi), .pause_n_o(pause_n), .sdo_i(sdo),
      .sdo_oe_i(sdo_oe));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop;
      if (n_fail == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic op(input logic [15:0] d, input int n, input bit m3 = 1'b0, input int pz = -1);
      @(posedge clk) #1;
      m.frame(d, n, m3, pz, rx);
   endtask
   task automatic rd(input logic [7:0] e, input int pz = -1);
      op(16'h0500, 16, 1'b0, pz);
      cmp("status", e, rx);
   endtask
   task automatic idle;
      for (int k = 0; k < 1000 && busy !== 1'b0; k++)
         @(posedge clk);
      cmp("busy", 8'h00, {7'h00, busy});
   endtask
   task automatic t_reset;
      rd(8'h00);
      cmp("level", 8'h00, {6'h00, lvl});
   endtask
   task automatic t_latch;
      op(16'h000E, 8, 1'b1);
      rd(8'h02, 3);
      op(16'h0004, 8);
      rd(8'h00);
      op(16'h018C, 16);
      idle;
      rd(8'h00);
   endtask
   task automatic t_write_status_cmd;
      op(16'h0006, 8);
      op(16'h01FF, 16);
      rd(8'hFF);
      op(16'h0006, 8);
      idle;
      rd(8'h8C);
      cmp("level", 8'h03, {6'h00, lvl});
   endtask
   task automatic t_guard;
      @(posedge clk) #1 guard_n = 1'b0;
      op(16'h0006, 8);
      op(16'h0100, 16);
      idle;
      cmp("level", 8'h03, {6'h00, lvl});
      @(posedge clk) #1 guard_n = 1'b1;
      op(16'h0006, 8);
      op(16'h0100, 16);
      idle;
      rd(8'h00);
      cmp("level", 8'h00, {6'h00, lvl});
   endtask
   initial begin
      rst_n = 1'b0;
      guard_n = 1'b1;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      t_reset;
      t_latch;
      t_write_status_cmd;
      t_guard;
      report_and_stop;
   end
   initial begin
      // Whole run needs about 30 us
      #300us;
      n_fail++;
      report_and_stop;
   end
endmodule // spisp_top_tb
